// File: hw/pawg_top.sv
// wait-state generator between cpu bus and peripheral bus
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - stall cpu until peripheral data is valid
// - only listed registers and directions stall
// - watchdog mode write inserts three waits
// - immediate watchdog write totals ten clocks
// - serial status read inserts one wait
// - other accesses keep five-clock baseline
// - converter writes wait by clock select
// - converter result read waits by select
// - max wait is two macro periods plus one
// - fraction dropped up to and at low phase, else up
// - computed count one means no write wait
// - result read still waits one cycle
// - ten megahertz examples give listed counts
// - waits counted in cpu clock cycles
module pawg_top
	import pawg_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// apb register port
	input  wire logic [APB_ADDR_W-1:0] paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// cpu bus access
	input  wire logic                  cpuReq,
	input  wire logic                  cpuWrite,
	input  wire logic [SFR_ADDR_W-1:0] cpuAddr,
	input  wire logic [SFR_DATA_W-1:0] cpuWdata,
	output logic                       cpuReady,
	output logic                       cpuStall,
	// peripheral bus strobe
	output logic                       perStrobe,
	output logic                       perWrite,
	output logic      [SFR_ADDR_W-1:0] perAddr,
	output logic      [SFR_DATA_W-1:0] perWdata
);

	// ------------------------------------------------------------
	// elaboration checks on the shared constants
	// ------------------------------------------------------------
	// the longest converter wait is nine cycles; a narrower count would
	// wrap and let the cpu through before the peripheral side settled
	generate
		if (WAIT_W < 4) begin : gWaitWidthCheck
			$error("pawg_top: WAIT_W must be at least 4");
		end
		if (CONV_CLK_SEL_POS >= SFR_DATA_W) begin : gClkSelPosCheck
			$error("pawg_top: clock select bit outside the data byte");
		end
		if ((WAIT_WATCHDOG == WAIT_NONE) || (WAIT_SERIAL == WAIT_NONE))
		begin : gFixedWaitCheck
			$error("pawg_top: fixed wait counts must not be zero");
		end
		if (STALL_CNT_W > 32) begin : gStallCntCheck
			$error("pawg_top: stall counter wider than the data bus");
		end
		if (ST_MAXWAIT_LSB + WAIT_W > 32) begin : gStatusFitCheck
			$error("pawg_top: wait field outside the status word");
		end
	endgenerate

	// ------------------------------------------------------------
	// register decode on the cpu address
	// ------------------------------------------------------------
	logic [WAIT_W-1:0] maxWait;
	logic [WAIT_W-1:0] convWriteWait;
	logic [WAIT_W-1:0] waitCount;
	logic              hitWatchdog;
	logic              hitSerial;
	logic              hitConvWrite;
	logic              hitConvRead;
	logic              waitedAccess;
	logic              accessDone;

	assign hitWatchdog  = cpuWrite && (cpuAddr == SFR_WATCHDOG_MODE);
	assign hitSerial    = !cpuWrite && ((cpuAddr == SFR_SERIAL0_RX_STATUS)
		|| (cpuAddr == SFR_SERIAL6_RX_STATUS));
	assign hitConvWrite = cpuWrite && ((cpuAddr == SFR_CONVERTER_MODE)
		|| (cpuAddr == SFR_CONVERTER_CHANNEL)
		|| (cpuAddr == SFR_COMPARE_MODE)
		|| (cpuAddr == SFR_COMPARE_THRESHOLD));
	assign hitConvRead  = !cpuWrite && (cpuAddr == SFR_CONVERTER_RESULT);

	// a computed count of one hides the wait for writes only
	assign convWriteWait = (maxWait == WAIT_ONE) ? WAIT_NONE : maxWait;
	// converter accesses take the worst-case count, except a write with a count of one: a few cycles
	// lost, but the cpu never sees data from a half-finished crossing
	// maxWait is zero only in reset and the first cycle after it, so past that the result read always waits
	assign waitCount = hitWatchdog  ? WAIT_WATCHDOG :
	                   hitSerial    ? WAIT_SERIAL :
	                   hitConvWrite ? convWriteWait :
	                   hitConvRead  ? maxWait :
	                   WAIT_NONE;
	assign waitedAccess = waitCount != WAIT_NONE;
	assign accessDone   = cpuReq && cpuReady;

	// ------------------------------------------------------------
	// stall timer and wait count calculation
	// ------------------------------------------------------------
	logic                 convClkSel_reg;
	logic [CPU_DIV_W-1:0] cpuDiv_reg;
	logic                 oscStop_reg;

	pawg_stall_timer #(
		.WIDTH (WAIT_W)
	) uStallTimer (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.cpuReq    (cpuReq),
		.waitCount (waitCount),
		.cpuReady  (cpuReady),
		.cpuStall  (cpuStall)
	);

	pawg_wait_calc uWaitCalc (
		.clk_sys    (clk_sys),
		.resetn     (resetn),
		.convClkSel (convClkSel_reg),
		.cpuDiv     (cpuDiv_reg),
		.maxWait    (maxWait)
	);

	// ------------------------------------------------------------
	// converter clock select snooped from converter mode writes
	// ------------------------------------------------------------
	logic convModeWrite;
	logic convClkSel_next;

	// only a completed write moves the select, so an access that is still
	// being stalled never has its own wait count changed under it
	assign convModeWrite   = accessDone && cpuWrite
		&& (cpuAddr == SFR_CONVERTER_MODE);
	assign convClkSel_next = convModeWrite ? cpuWdata[CONV_CLK_SEL_POS]
		: convClkSel_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			convClkSel_reg <= CONV_CLK_SEL_RESET;
		end else begin
			convClkSel_reg <= convClkSel_next;
		end
	end

	// ------------------------------------------------------------
	// peripheral side strobe, one per completed access
	// ------------------------------------------------------------
	// launched only once the stall has run out, so the slow side sees a
	// single settled access rather than every repeated attempt
	logic                  perStrobe_reg;
	logic                  perWrite_reg;
	logic [SFR_ADDR_W-1:0] perAddr_reg;
	logic [SFR_DATA_W-1:0] perWdata_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			perStrobe_reg <= 1'b0;
			perWrite_reg  <= 1'b0;
			perAddr_reg   <= '0;
			perWdata_reg  <= '0;
		end else begin
			perStrobe_reg <= accessDone;
			if (accessDone) begin
				perWrite_reg <= cpuWrite;
				perAddr_reg  <= cpuAddr;
				perWdata_reg <= cpuWdata;
			end
		end
	end

	assign perStrobe = perStrobe_reg;
	assign perWrite  = perWrite_reg;
	assign perAddr   = perAddr_reg;
	assign perWdata  = perWdata_reg;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic apbSetup;
	logic apbAccess;
	logic apbWrite;
	logic selConfig;
	logic selStatus;
	logic selLastWait;
	logic selStallCount;
	logic apbMapped;

	assign apbSetup      = psel && !penable;
	assign apbAccess     = psel && penable;
	assign apbWrite      = apbAccess && pwrite;
	assign selConfig     = paddr == REG_CONFIG;
	assign selStatus     = paddr == REG_STATUS;
	assign selLastWait   = paddr == REG_LAST_WAIT;
	assign selStallCount = paddr == REG_STALL_COUNT;
	assign apbMapped     = selConfig || selStatus || selLastWait
		|| selStallCount;
	// every register answers from settled flops, so no wait state is needed
	assign pready        = 1'b1;
	assign pslverr       = apbAccess && !apbMapped;

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	logic                   violation_reg;
	logic                   violation_next;
	logic                   violationSet;
	logic                   violationClr;
	logic [WAIT_W-1:0]      lastWait_reg;
	logic [STALL_CNT_W-1:0] stallCount_reg;
	logic [STALL_CNT_W-1:0] stallCount_next;
	logic                   stallCountFull;
	logic [CPU_DIV_W-1:0]   cpuDivWr;

	// ratios beyond the slowest supported divider are clamped to it
	assign cpuDivWr = (pwdata[CFG_DIV_LSB +: CPU_DIV_W] > CPU_DIV_MAX)
		? CPU_DIV_MAX : pwdata[CFG_DIV_LSB +: CPU_DIV_W];

	// the cpu must not make a waited access with the oscillator stopped;
	// such an access is still stalled but is flagged for software
	assign violationSet   = accessDone && waitedAccess && oscStop_reg;
	assign violationClr   = apbWrite && selStatus && pwdata[ST_VIOLATION];
	assign violation_next = violationSet || (violation_reg && !violationClr);

	// counter saturates instead of wrapping, so a long run reads as full
	assign stallCountFull  = &stallCount_reg;
	assign stallCount_next =
		(apbWrite && selStallCount) ? {{(STALL_CNT_W-1){1'b0}}, cpuStall} :
		(cpuStall && !stallCountFull) ? stallCount_reg + 16'h0001 :
		stallCount_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cpuDiv_reg  <= CFG_DIV_RESET;
			oscStop_reg <= 1'b0;
		end else if (apbWrite && selConfig) begin
			cpuDiv_reg  <= cpuDivWr;
			oscStop_reg <= pwdata[CFG_OSC_STOP];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			violation_reg  <= 1'b0;
			lastWait_reg   <= WAIT_NONE;
			stallCount_reg <= '0;
		end else begin
			violation_reg  <= violation_next;
			stallCount_reg <= stallCount_next;
			if (accessDone) begin
				lastWait_reg <= waitCount;
			end
		end
	end

	// ------------------------------------------------------------
	// read data, captured in the setup phase
	// ------------------------------------------------------------
	logic [31:0] readConfig;
	logic [31:0] readStatus;
	logic [31:0] readMux;
	logic [31:0] prdata_reg;

	always_comb begin
		readConfig                           = 32'h00000000;
		readConfig[CFG_DIV_LSB +: CPU_DIV_W] = cpuDiv_reg;
		readConfig[CFG_OSC_STOP]             = oscStop_reg;
	end

	// stall bit is live, so software polling it sees the cpu side now
	always_comb begin
		readStatus                              = 32'h00000000;
		readStatus[ST_STALL]                    = cpuStall;
		readStatus[ST_CLK_SEL]                  = convClkSel_reg;
		readStatus[ST_VIOLATION]                = violation_reg;
		readStatus[ST_MAXWAIT_LSB +: WAIT_W]    = maxWait;
	end

	assign readMux =
		selConfig     ? readConfig :
		selStatus     ? readStatus :
		selLastWait   ? {28'h0000000, lastWait_reg} :
		selStallCount ? {16'h0000, stallCount_reg} :
		32'h00000000;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata_reg <= 32'h00000000;
		end else if (apbSetup && !pwrite) begin
			prdata_reg <= readMux;
		end
	end

	assign prdata = prdata_reg;

endmodule : pawg_top
`default_nettype wire

// File: hw/pawg_pkg.sv
// constants and types shared by the peripheral access wait generator
package pawg_pkg;

	// ------------------------------------------------------------
	// cpu side special function register addresses
	// ------------------------------------------------------------
	localparam int unsigned SFR_ADDR_W            = 8;
	localparam int unsigned SFR_DATA_W            = 8;
	localparam logic [7:0]  SFR_WATCHDOG_MODE     = 8'h99;
	localparam logic [7:0]  SFR_SERIAL0_RX_STATUS = 8'hA3;
	localparam logic [7:0]  SFR_SERIAL6_RX_STATUS = 8'h53;
	localparam logic [7:0]  SFR_CONVERTER_MODE    = 8'h80;
	localparam logic [7:0]  SFR_CONVERTER_CHANNEL = 8'h81;
	localparam logic [7:0]  SFR_COMPARE_MODE      = 8'h82;
	localparam logic [7:0]  SFR_COMPARE_THRESHOLD = 8'h83;
	localparam logic [7:0]  SFR_CONVERTER_RESULT  = 8'h84;
	localparam int unsigned CONV_CLK_SEL_POS      = 5;
	localparam logic        CONV_CLK_SEL_RESET    = 1'b0;

	// ------------------------------------------------------------
	// wait counts, all in cpu clock cycles
	// ------------------------------------------------------------
	localparam int unsigned WAIT_W         = 4;
	localparam logic [3:0]  WAIT_NONE      = 4'h0;
	localparam logic [3:0]  WAIT_ONE       = 4'h1;
	localparam logic [3:0]  WAIT_WATCHDOG  = 4'h3;
	localparam logic [3:0]  WAIT_SERIAL    = 4'h1;
	// macro clock = oscillator >> shift (1: /2 when select=1, 2: /4)
	localparam logic [1:0]  MACRO_SHIFT_HI = 2'h1;
	localparam logic [1:0]  MACRO_SHIFT_LO = 2'h2;
	localparam int unsigned CPU_DIV_W      = 3;
	localparam logic [2:0]  CPU_DIV_MAX    = 3'h4;

	// ------------------------------------------------------------
	// apb register map
	// ------------------------------------------------------------
	localparam int unsigned APB_ADDR_W      = 12;
	localparam logic [11:0] REG_CONFIG      = 12'h000;
	localparam logic [11:0] REG_STATUS      = 12'h004;
	localparam logic [11:0] REG_LAST_WAIT   = 12'h008;
	localparam logic [11:0] REG_STALL_COUNT = 12'h00C;
	localparam int unsigned CFG_DIV_LSB     = 0;
	localparam int unsigned CFG_OSC_STOP    = 4;
	localparam logic [2:0]  CFG_DIV_RESET   = 3'h0;
	localparam int unsigned ST_STALL        = 0;
	localparam int unsigned ST_CLK_SEL      = 1;
	localparam int unsigned ST_VIOLATION    = 2;
	localparam int unsigned ST_MAXWAIT_LSB  = 4;
	localparam int unsigned STALL_CNT_W     = 16;

	typedef enum {
		STALL_IDLE,
		STALL_WAIT
	} pawg_stall_state_type;

endpackage : pawg_pkg

// File: hw/pawg_wait_calc.sv
// converter wait count from macro clock and cpu clock ratio
`timescale 1ns/100ps
`default_nettype none
module pawg_wait_calc
	import pawg_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// settings
	input  wire logic                 convClkSel,
	input  wire logic [CPU_DIV_W-1:0] cpuDiv,
	// result
	output logic      [WAIT_W-1:0]    maxWait
);

	// ------------------------------------------------------------
	// quotient of two macro periods over one cpu period
	// ------------------------------------------------------------
	// both periods are counted in oscillator cycles, so the quotient is
	// a shift; the bits shifted out are the fraction in oscillator cycles
	logic [1:0]        macroShift;
	logic [7:0]        numerator;
	logic [7:0]        divMask;
	logic [7:0]        remainder;
	logic [7:0]        halfCpu;
	logic [7:0]        quotient;
	logic              roundUp;
	logic [WAIT_W-1:0] maxWait_next;
	logic [WAIT_W-1:0] maxWait_reg;

	assign macroShift = convClkSel ? MACRO_SHIFT_HI : MACRO_SHIFT_LO;
	assign numerator  = 8'h02 << macroShift;
	assign divMask    = (8'h01 << cpuDiv) - 8'h01;
	assign quotient   = numerator >> cpuDiv;
	assign remainder  = numerator & divMask;
	// low phase of the cpu clock is half its period
	assign halfCpu    = (8'h01 << cpuDiv) >> 1;
	// equal to the low phase counts as not exceeding it: dropped
	assign roundUp    = remainder > halfCpu;
	assign maxWait_next = WAIT_W'(quotient + {7'h00, roundUp} + 8'h01);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			maxWait_reg <= WAIT_NONE;
		end else begin
			maxWait_reg <= maxWait_next;
		end
	end

	assign maxWait = maxWait_reg;

endmodule : pawg_wait_calc
`default_nettype wire

// File: hw/pawg_stall_timer.sv
// holds the cpu access for a given number of cpu clock cycles
`timescale 1ns/100ps
`default_nettype none
module pawg_stall_timer
	import pawg_pkg::*;
#(
	parameter int unsigned WIDTH = WAIT_W
)
(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// cpu access
	input  wire logic             cpuReq,
	input  wire logic [WIDTH-1:0] waitCount,
	output logic                  cpuReady,
	output logic                  cpuStall
);

	generate
		if (WIDTH < 2) begin : gWidthCheck
			$error("pawg_stall_timer: WIDTH must be at least 2");
		end
	endgenerate

	pawg_stall_state_type state_reg;
	pawg_stall_state_type state_next;
	logic [WIDTH-1:0]     count_reg;
	logic [WIDTH-1:0]     count_next;
	logic                 needWait;

	assign needWait = waitCount != '0;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			STALL_IDLE: begin
				// first cycle of the access already counts as one wait
				if (cpuReq && needWait) begin
					state_next = STALL_WAIT;
					count_next = waitCount - WIDTH'(1);
				end
			end
			STALL_WAIT: begin
				if (count_reg == '0) begin
					state_next = STALL_IDLE;
				end else begin
					count_next = count_reg - WIDTH'(1);
				end
			end
			default: begin
				state_next = STALL_IDLE;
				count_next = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= STALL_IDLE;
			count_reg <= '0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// the cpu keeps repeating the access while ready stays low
	assign cpuReady = cpuReq && (((state_reg == STALL_IDLE) && !needWait)
		|| ((state_reg == STALL_WAIT) && (count_reg == '0)));
	assign cpuStall = cpuReq && !cpuReady;

endmodule : pawg_stall_timer
`default_nettype wire

// File: test/pawg_chk.sv
// concurrent checks on the wait generator ports
`timescale 1ns/100ps
`default_nettype none
module pawg_chk
	import pawg_pkg::*;
(
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  resetn,
	// apb
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// cpu bus
	input wire logic                  cpuReq,
	input wire logic                  cpuWrite,
	input wire logic [SFR_ADDR_W-1:0] cpuAddr,
	input wire logic [SFR_DATA_W-1:0] cpuWdata,
	input wire logic                  cpuReady,
	input wire logic                  cpuStall,
	// peripheral strobe
	input wire logic                  perStrobe,
	input wire logic                  perWrite,
	input wire logic [SFR_ADDR_W-1:0] perAddr,
	input wire logic [SFR_DATA_W-1:0] perWdata
);
	logic pendReg;
	// a request is new when no stall of it was seen last cycle
	wire logic firstReq = cpuReq && !pendReg;
	wire logic convWr = cpuWrite && cpuAddr >= SFR_CONVERTER_MODE
		&& cpuAddr <= SFR_COMPARE_THRESHOLD;
	wire logic serRd = !cpuWrite && (cpuAddr == SFR_SERIAL0_RX_STATUS
		|| cpuAddr == SFR_SERIAL6_RX_STATUS);
	wire logic resRd = !cpuWrite && cpuAddr == SFR_CONVERTER_RESULT;
	wire logic wdWr = cpuWrite && cpuAddr == SFR_WATCHDOG_MODE;
	wire logic regHit = paddr == REG_CONFIG || paddr == REG_STATUS
		|| paddr == REG_LAST_WAIT || paddr == REG_STALL_COUNT;

	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
			pendReg <= 1'b0;
		else
			pendReg <= cpuReq && !cpuReady;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_wait3;
		cpuStall [*3] ##1 cpuReady;
	endsequence

	a_watchdog_wait: assert property (
		firstReq && wdWr |-> s_wait3) else $error("watchdog wait wrong");
	a_serial_wait: assert property (
		firstReq && serRd |-> cpuStall ##1 cpuReady)
		else $error("serial status wait wrong");
	a_plain_nowait: assert property (
		firstReq && !(wdWr || serRd || resRd || convWr) |-> cpuReady)
		else $error("unlisted access stalled");
	a_result_wait: assert property (
		firstReq && resRd |-> !cpuReady ##[1:9] cpuReady)
		else $error("result read wait wrong");
	a_conv_nosingle: assert property (
		firstReq && convWr |-> cpuReady or (cpuStall ##1 cpuStall))
		else $error("converter write waited one");
	a_stall_bound: assert property (
		cpuReq |-> ##[0:9] cpuReady) else $error("stall too long");
	a_per_copy: assert property (
		cpuReq && cpuReady |=> perStrobe && perAddr == $past(cpuAddr)
		&& perWrite == $past(cpuWrite) && perWdata == $past(cpuWdata))
		else $error("peripheral copy wrong");
	a_per_cause: assert property (
		perStrobe |-> $past(cpuReq && cpuReady))
		else $error("stray peripheral strobe");
	a_apb_decode: assert property (
		psel && penable |-> pready && pslverr == !regHit)
		else $error("apb decode wrong");
endmodule : pawg_chk
`default_nettype wire

// File: test/pawg_cpu_model.sv
// cpu core model: one sfr access, held until the block takes it
`timescale 1ns/100ps
`default_nettype none
module pawg_cpu_model
	import pawg_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// command from the bench
	input  wire logic                  go,
	input  wire logic                  goWr,
	input  wire logic [SFR_ADDR_W-1:0] goAddr,
	input  wire logic [SFR_DATA_W-1:0] goData,
	output logic                       done,
	output logic      [WAIT_W-1:0]     waits,
	// cpu bus
	output logic                       cpuReq,
	output logic                       cpuWrite,
	output logic      [SFR_ADDR_W-1:0] cpuAddr,
	output logic      [SFR_DATA_W-1:0] cpuWdata,
	input  wire logic                  cpuReady
);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cpuReq <= 1'b0;
			cpuWrite <= 1'b0;
			cpuAddr <= 8'h00;
			cpuWdata <= 8'h00;
			done <= 1'b0;
			waits <= 4'h0;
		end else begin
			done <= 1'b0;
			if (cpuReq && cpuReady) begin
				// released lines turn over so a stale value never passes
				cpuReq <= 1'b0;
				done <= 1'b1;
				cpuWrite <= ~cpuWrite;
				cpuAddr <= ~cpuAddr;
				cpuWdata <= ~cpuWdata;
			end else if (cpuReq) begin
				waits <= waits + 4'h1;
			end else if (go) begin
				cpuReq <= 1'b1;
				cpuWrite <= goWr;
				cpuAddr <= goAddr;
				cpuWdata <= goData;
				waits <= 4'h0;
			end
		end
	end
endmodule : pawg_cpu_model
`default_nettype wire

// File: test/peripheral_access_wait_gen_tb.sv
// self-checking bench for the peripheral access wait generator
`timescale 1ns/100ps
`default_nettype none
module peripheral_access_wait_gen_tb
	import pawg_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        resetn  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h0;
	logic        go      = 1'b0;
	logic        goWr    = 1'b0;
	logic [7:0]  goAddr  = 8'h00;
	logic [7:0]  goData  = 8'h00;
	wire  [31:0] prdata;
	wire         pready, pslverr, cpuReq, cpuWrite, cpuReady, cpuStall;
	wire  [7:0]  cpuAddr, cpuWdata, perAddr, perWdata;
	wire         perStrobe, perWrite, done;
	wire  [3:0]  waits;
	logic [31:0] rd;
	logic        er;
	int          nFail = 0;
	int          totalChecks = 0;
	// direction, sfr address, expected waits
	logic [12:0] tab [12] = '{13'h1993, 13'h0990, 13'h0A31, 13'h0531,
		13'h1A30, 13'h1100, 13'h0800, 13'h1819, 13'h1829, 13'h1839,
		13'h0849, 13'h1809};
	logic [3:0]  wt [2][5] = '{'{4'h9, 4'h5, 4'h3, 4'h2, 4'h0},
		'{4'h5, 4'h3, 4'h2, 4'h0, 4'h0}};

	initial forever #2.5 clk_sys = ~clk_sys;

	pawg_top dut (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
		.cpuWdata(cpuWdata), .cpuReady(cpuReady), .cpuStall(cpuStall),
		.perStrobe(perStrobe), .perWrite(perWrite), .perAddr(perAddr),
		.perWdata(perWdata));
	pawg_cpu_model cpuCore (.clk_sys(clk_sys), .resetn(resetn), .go(go),
		.goWr(goWr), .goAddr(goAddr), .goData(goData), .done(done),
		.waits(waits), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
		.cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuReady(cpuReady));

	task automatic finalReport();
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finalReport

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("BAD %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			$display("BAD %0t: apb answer timed out", $time);
			nFail++;
			finalReport();
		end
	endtask : apb

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask : rdchk

	// one sfr access; waits and the peripheral copy are compared
	task automatic cpu(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [3:0] e);
		int i;
		@(posedge clk_sys);
		go <= 1'b1;
		goWr <= w;
		goAddr <= a;
		goData <= d;
		@(posedge clk_sys);
		go <= 1'b0;
		for (i = 0; i < 40; i++) begin
			@(posedge clk_sys);
			#1;
			if (done === 1'b1)
				break;
		end
		if (i == 40) begin
			$display("BAD %0t: cpu access timed out", $time);
			nFail++;
			finalReport();
		end
		check({28'h0, waits}, {28'h0, e});
		check({14'h0, perStrobe, perWrite, perAddr, perWdata},
			{14'h0, 1'b1, w, a, d});
	endtask : cpu

	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		rdchk(REG_CONFIG, 32'h0, 32'hFFFFFFFF);
		rdchk(REG_STATUS, 32'h90, 32'hFF);
		apb(1'b0, 12'h010, 32'h0);
		check({31'h0, er}, 32'h1);
		apb(1'b1, REG_CONFIG, 32'h7);
		rdchk(REG_CONFIG, 32'h4, 32'h7);
		apb(1'b1, REG_CONFIG, 32'h0);
		for (int k = 0; k < 12; k++)
			cpu(tab[k][12], tab[k][11:4], 8'h5A, tab[k][3:0]);
		rdchk(REG_LAST_WAIT, 32'h9, 32'hF);
		for (int s = 0; s < 2; s++) begin
			for (int dv = 0; dv < 5; dv++) begin
				apb(1'b1, REG_CONFIG, dv);
				cpu(1'b1, SFR_CONVERTER_CHANNEL, 8'h3C, wt[s][dv]);
				cpu(1'b0, SFR_CONVERTER_RESULT, 8'h00,
					wt[s][dv] == 4'h0 ? 4'h1 : wt[s][dv]);
			end
			apb(1'b1, REG_CONFIG, 32'h0);
			cpu(1'b1, SFR_CONVERTER_MODE, 8'h20, wt[s][0]);
		end
		rdchk(REG_STATUS, 32'h52, 32'hFF);
		apb(1'b1, REG_STALL_COUNT, 32'h0);
		cpu(1'b1, SFR_WATCHDOG_MODE, 8'hC3, 4'h3);
		rdchk(REG_STALL_COUNT, 32'h3, 32'hFFFF);
		// oscillator stopped: the access is misused on purpose
		apb(1'b1, REG_CONFIG, 32'h10);
		cpu(1'b1, SFR_WATCHDOG_MODE, 8'h11, 4'h3);
		rdchk(REG_STATUS, 32'h4, 32'h4);
		apb(1'b1, REG_STATUS, 32'h4);
		rdchk(REG_STATUS, 32'h0, 32'h4);
		// mid-run reset: select, counters and settings back to idle
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		rdchk(REG_CONFIG, 32'h0, 32'hFFFFFFFF);
		rdchk(REG_STATUS, 32'h90, 32'hFF);
		rdchk(REG_LAST_WAIT, 32'h0, 32'hF);
		rdchk(REG_STALL_COUNT, 32'h0, 32'hFFFF);
		cpu(1'b1, SFR_CONVERTER_CHANNEL, 8'h00, 4'h9);
		finalReport();
	end
endmodule : peripheral_access_wait_gen_tb

bind pawg_top pawg_chk u_chk (.clk_sys(clk_sys), .resetn(resetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
	.cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuReady(cpuReady),
	.cpuStall(cpuStall), .perStrobe(perStrobe), .perWrite(perWrite),
	.perAddr(perAddr), .perWdata(perWdata));
`default_nettype wire
